// file: design/clkgen_if.sv
// link between the graphics controller and the clock word decoder
`timescale 1ns/1ns
interface clkgen_if;
    logic        load_valid;
    logic [2:0]  load_addr;
    logic [20:0] load_data;
    logic [1:0]  sel;
    logic        standby_request_n;

    modport device (
        input load_valid,
        input load_addr,
        input load_data,
        input sel,
        input standby_request_n
    );
    modport host (
        output load_valid,
        output load_addr,
        output load_data,
        output sel,
        output standby_request_n
    );
endinterface : clkgen_if

// file: design/clkgen_pkg.sv
// shared constants, field layouts and types of the dual clock word decoder
package clkgen_pkg;
    localparam int WORD_W  = 21;
    localparam int IDX_W   = 4;
    localparam int NFLD_W  = 7;
    localparam int RFLD_W  = 3;
    localparam int MFLD_W  = 7;
    localparam int IDX_LSB = 17;
    localparam int N_LSB   = 10;
    localparam int R_LSB   = 7;
    localparam int M_LSB   = 0;

    localparam logic [7:0] N_OFFSET  = 8'h03;
    localparam logic [7:0] M_OFFSET  = 8'h02;
    localparam logic [2:0] PRESCALE_LO = 3'h2;
    localparam logic [2:0] PRESCALE_HI = 3'h4;

    localparam logic [3:0] IDX_PIX_OFF      = 4'he;
    localparam logic [3:0] IDX_PIX_FROM_MEM = 4'hf;

    localparam logic [2:0] ADDR_PIX0     = 3'h0;
    localparam logic [2:0] ADDR_PIX1     = 3'h1;
    localparam logic [2:0] ADDR_PIX2     = 3'h2;
    localparam logic [2:0] ADDR_MEM      = 3'h3;
    localparam logic [2:0] ADDR_STBY_DIV = 3'h4;
    localparam logic [2:0] ADDR_OPTION   = 3'h6;

    localparam int OPT_STBY_MODE_BIT = 20;
    localparam int OPT_PRESCALE_LSB  = 12;

    localparam logic [20:0] OPTION_RESET    = 21'h010000;
    localparam logic [20:0] FREQ_WORD_RESET = 21'h000000;
    localparam logic [3:0]  STBY_DIV_RESET  = 4'h8;
    localparam logic [4:0]  STBY_HALF_BASE  = 5'h11;

    localparam logic [31:0] VCO_MIN_KHZ = 32'd50000;
    localparam logic [31:0] VCO_MAX_KHZ = 32'd120000;

    typedef struct packed {
        logic [3:0] index;
        logic [7:0] n_eff;
        logic [7:0] m_eff;
        logic [2:0] prescale;
        logic [7:0] divisor;
    } decode_t;

    typedef enum logic [4:0] {
        PIX_OWN  = 5'h01,
        PIX_OFF  = 5'h02,
        PIX_MEM  = 5'h04,
        PIX_HIGH = 5'h08,
        PIX_STOP = 5'h10
    } pix_src_t;

    typedef enum logic [2:0] {
        MEM_VCO  = 3'h1,
        MEM_SLOW = 3'h2,
        MEM_STOP = 3'h4
    } mem_src_t;

    typedef enum logic [2:0] {
        ST_RUN  = 3'h1,
        ST_SLOW = 3'h2,
        ST_DEEP = 3'h4
    } stby_t;

    function automatic decode_t decode_word(input logic [20:0] w,
                                            input logic        ps);
        decode_t d;
        d.index    = w[IDX_LSB +: IDX_W];
        d.n_eff    = {1'b0, w[N_LSB +: NFLD_W]} + N_OFFSET;
        d.m_eff    = {1'b0, w[M_LSB +: MFLD_W]} + M_OFFSET;
        d.prescale = ps ? PRESCALE_HI : PRESCALE_LO;
        d.divisor  = 8'h01 << w[R_LSB +: RFLD_W];
        return d;
    endfunction : decode_word
endpackage : clkgen_pkg

// file: design/clock_word_decoder.sv
// device end: frequency word store, decode and standby control
`timescale 1ns/1ns
module clock_word_decoder (
    input  wire logic                CLK,
    input  wire logic                RST,
    clkgen_if.device                 link,
    output clkgen_pkg::decode_t      PIX_CFG,
    output clkgen_pkg::pix_src_t     PIXEL_CLOCK_OUT_SEL,
    output logic                     PIX_VCO_ON,
    output clkgen_pkg::decode_t      MEM_CFG,
    output clkgen_pkg::mem_src_t     MEM_CLOCK_SEL,
    output logic                     MEM_VCO_ON,
    output logic                     STANDBY_MEMORY_FREQ_CLK,
    output logic                     OSC_ON,
    output clkgen_pkg::stby_t        STANDBY_STATE
);
    logic [20:0]          pix_word_reg [3];
    logic [20:0]          pix_word_next [3];
    logic [20:0]          mem_word_reg;
    logic [20:0]          mem_word_next;
    logic [20:0]          option_word_reg;
    logic [20:0]          option_word_next;
    logic [3:0]           standby_divisor_reg;
    logic [3:0]           standby_divisor_next;
    logic                 pin_meta_reg;
    logic                 pin_sync_reg;
    clkgen_pkg::stby_t    stby_reg;
    clkgen_pkg::stby_t    stby_next;
    logic [4:0]           slow_cnt_reg;
    logic [4:0]           slow_cnt_next;
    logic                 slow_clk_reg;
    logic                 slow_clk_next;
    logic [4:0]           half_count;
    logic [3:0]           div_code;
    logic [1:0]           sel_idx;
    clkgen_pkg::decode_t  pix_dec;
    clkgen_pkg::decode_t  mem_dec;
    clkgen_pkg::decode_t  pix_cfg_reg;
    clkgen_pkg::decode_t  pix_cfg_next;
    clkgen_pkg::decode_t  mem_cfg_reg;
    clkgen_pkg::pix_src_t pix_src_reg;
    clkgen_pkg::pix_src_t pix_src_next;
    clkgen_pkg::mem_src_t mem_src_reg;
    clkgen_pkg::mem_src_t mem_src_next;
    logic                 pix_vco_reg;
    logic                 pix_vco_next;
    logic                 mem_vco_reg;
    logic                 mem_vco_next;
    logic                 osc_reg;
    logic                 osc_next;

    // only three pixel registers exist; select code 3 reuses the last one
    function automatic logic [1:0] pix_slot(input logic [1:0] s);
        return (s == 2'h3) ? 2'h2 : s;
    endfunction : pix_slot

    // register writes; contents survive both standby modes
    always_comb begin
        pix_word_next        = pix_word_reg;
        mem_word_next        = mem_word_reg;
        option_word_next     = option_word_reg;
        standby_divisor_next = standby_divisor_reg;
        if (link.load_valid) begin
            if (link.load_addr == clkgen_pkg::ADDR_PIX0) begin
                pix_word_next[0] = link.load_data;
            end else if (link.load_addr == clkgen_pkg::ADDR_PIX1) begin
                pix_word_next[1] = link.load_data;
            end else if (link.load_addr == clkgen_pkg::ADDR_PIX2) begin
                pix_word_next[2] = link.load_data;
            end else if (link.load_addr == clkgen_pkg::ADDR_MEM) begin
                mem_word_next = link.load_data;
            end else if (link.load_addr == clkgen_pkg::ADDR_STBY_DIV) begin
                standby_divisor_next = link.load_data[3:0];
            end else if (link.load_addr == clkgen_pkg::ADDR_OPTION) begin
                option_word_next = link.load_data;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < 3; i++) begin
                pix_word_reg[i] <= clkgen_pkg::FREQ_WORD_RESET;
            end
            mem_word_reg        <= clkgen_pkg::FREQ_WORD_RESET;
            option_word_reg     <= clkgen_pkg::OPTION_RESET;
            standby_divisor_reg <= clkgen_pkg::STBY_DIV_RESET;
        end else begin
            pix_word_reg        <= pix_word_next;
            mem_word_reg        <= mem_word_next;
            option_word_reg     <= option_word_next;
            standby_divisor_reg <= standby_divisor_next;
        end
    end

    // the pin is driven by the far party and may float up on release
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
        end else begin
            pin_meta_reg <= link.standby_request_n;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // the mode bit is sampled only on entry, so the controller must set it
    // before the pin goes low
    always_comb begin
        stby_next = stby_reg;
        case (stby_reg)
            clkgen_pkg::ST_RUN: begin
                if (!pin_sync_reg) begin
                    if (option_word_reg[clkgen_pkg::OPT_STBY_MODE_BIT]) begin
                        stby_next = clkgen_pkg::ST_DEEP;
                    end else begin
                        stby_next = clkgen_pkg::ST_SLOW;
                    end
                end
            end
            default: begin
                if (pin_sync_reg) begin
                    stby_next = clkgen_pkg::ST_RUN;
                end
            end
        endcase
    end

    // code 0 is not valid; it falls back to the reset code's divisor
    always_comb begin
        div_code = (standby_divisor_reg == 4'h0) ? clkgen_pkg::STBY_DIV_RESET
                                                 : standby_divisor_reg;
        half_count = clkgen_pkg::STBY_HALF_BASE
                     - {1'b0, div_code};
        slow_cnt_next = 5'h00;
        slow_clk_next = 1'b0;
        if (stby_reg == clkgen_pkg::ST_SLOW) begin
            slow_clk_next = slow_clk_reg;
            if (slow_cnt_reg >= half_count - 5'h01) begin
                slow_cnt_next = 5'h00;
                slow_clk_next = !slow_clk_reg;
            end else begin
                slow_cnt_next = slow_cnt_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            stby_reg     <= clkgen_pkg::ST_RUN;
            slow_cnt_reg <= 5'h00;
            slow_clk_reg <= 1'b0;
        end else begin
            stby_reg     <= stby_next;
            slow_cnt_reg <= slow_cnt_next;
            slow_clk_reg <= slow_clk_next;
        end
    end

    // decode and output routing
    always_comb begin
        sel_idx = pix_slot(link.sel);
        pix_dec = clkgen_pkg::decode_word(pix_word_reg[sel_idx],
            option_word_reg[clkgen_pkg::OPT_PRESCALE_LSB +
                            32'(sel_idx)]);
        // no prescale bit exists for the memory word, so it uses factor two
        mem_dec = clkgen_pkg::decode_word(mem_word_reg, 1'b0);
        pix_cfg_next = pix_dec;
        pix_src_next = clkgen_pkg::PIX_OWN;
        pix_vco_next = 1'b1;
        mem_src_next = clkgen_pkg::MEM_VCO;
        mem_vco_next = 1'b1;
        osc_next     = 1'b1;
        if (pix_dec.index == clkgen_pkg::IDX_PIX_OFF) begin
            pix_src_next = clkgen_pkg::PIX_OFF;
        end else if (pix_dec.index == clkgen_pkg::IDX_PIX_FROM_MEM) begin
            pix_src_next          = clkgen_pkg::PIX_MEM;
            pix_vco_next          = 1'b0;
            pix_cfg_next          = mem_dec;
            pix_cfg_next.index    = pix_dec.index;
            pix_cfg_next.divisor  = pix_dec.divisor;
        end
        case (stby_reg)
            clkgen_pkg::ST_SLOW: begin
                pix_src_next = clkgen_pkg::PIX_HIGH;
                pix_vco_next = 1'b0;
                mem_vco_next = 1'b0;
                mem_src_next = clkgen_pkg::MEM_SLOW;
            end
            clkgen_pkg::ST_DEEP: begin
                pix_src_next = clkgen_pkg::PIX_STOP;
                pix_vco_next = 1'b0;
                mem_vco_next = 1'b0;
                mem_src_next = clkgen_pkg::MEM_STOP;
                osc_next     = 1'b0;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pix_cfg_reg <= '0;
            mem_cfg_reg <= '0;
            pix_src_reg <= clkgen_pkg::PIX_OWN;
            mem_src_reg <= clkgen_pkg::MEM_VCO;
            pix_vco_reg <= 1'b0;
            mem_vco_reg <= 1'b0;
            osc_reg     <= 1'b1;
        end else begin
            pix_cfg_reg <= pix_cfg_next;
            mem_cfg_reg <= mem_dec;
            pix_src_reg <= pix_src_next;
            mem_src_reg <= mem_src_next;
            pix_vco_reg <= pix_vco_next;
            mem_vco_reg <= mem_vco_next;
            osc_reg     <= osc_next;
        end
    end

    assign PIX_CFG                 = pix_cfg_reg;
    assign PIXEL_CLOCK_OUT_SEL     = pix_src_reg;
    assign PIX_VCO_ON              = pix_vco_reg;
    assign MEM_CFG                 = mem_cfg_reg;
    assign MEM_CLOCK_SEL           = mem_src_reg;
    assign MEM_VCO_ON              = mem_vco_reg;
    assign STANDBY_MEMORY_FREQ_CLK = slow_clk_reg;
    assign OSC_ON                  = osc_reg;
    assign STANDBY_STATE           = stby_reg;
endmodule : clock_word_decoder

// file: design/clock_word_programmer.sv
// controller end: range-checked frequency word writes and standby sequencing
`timescale 1ns/1ns
module clock_word_programmer #(
    parameter logic [31:0] REF_KHZ = 32'd14318
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    clkgen_if.host           link,
    input  wire logic        CMD_VALID,
    input  wire logic [2:0]  CMD_ADDR,
    input  wire logic [20:0] CMD_DATA,
    output logic             CMD_READY,
    output logic             CMD_REJECT,
    input  wire logic [1:0]  SEL_REQ,
    input  wire logic        STANDBY_REQ,
    input  wire logic        STANDBY_DEEP,
    output logic             STANDBY_ACTIVE
);
    typedef enum logic [2:0] {
        H_IDLE = 3'h1,
        H_PREP = 3'h2,
        H_LOW  = 3'h4
    } host_t;

    host_t       state_reg;
    host_t       state_next;
    logic        load_valid_reg;
    logic        load_valid_next;
    logic [2:0]  load_addr_reg;
    logic [2:0]  load_addr_next;
    logic [20:0] load_data_reg;
    logic [20:0] load_data_next;
    logic [20:0] option_shadow_reg;
    logic [20:0] option_shadow_next;
    logic        pin_reg;
    logic        pin_next;
    logic        reject_reg;
    logic        reject_next;
    logic        is_freq;
    logic        ps_bit;
    logic [31:0] num_khz;
    logic [31:0] m_eff;
    logic        in_range;

    // vco check without division: 50 MHz * M <= P * N * fref <= 120 MHz * M
    always_comb begin
        is_freq = (CMD_ADDR <= clkgen_pkg::ADDR_MEM);
        ps_bit  = (CMD_ADDR == clkgen_pkg::ADDR_MEM) ? 1'b0 :
                  option_shadow_reg[clkgen_pkg::OPT_PRESCALE_LSB +
                                    32'(CMD_ADDR[1:0])];
        num_khz = 32'((ps_bit ? 32'd4 : 32'd2) *
                  (32'(CMD_DATA[clkgen_pkg::N_LSB +: clkgen_pkg::NFLD_W]) +
                   32'(clkgen_pkg::N_OFFSET)) * REF_KHZ);
        m_eff   = 32'(CMD_DATA[clkgen_pkg::M_LSB +: clkgen_pkg::MFLD_W]) +
                  32'(clkgen_pkg::M_OFFSET);
        in_range = (num_khz >= 32'(clkgen_pkg::VCO_MIN_KHZ * m_eff)) &&
                   (num_khz <= 32'(clkgen_pkg::VCO_MAX_KHZ * m_eff));
    end

    assign CMD_READY = (state_reg == H_IDLE) && !STANDBY_REQ;

    always_comb begin
        state_next         = state_reg;
        load_valid_next    = 1'b0;
        load_addr_next     = load_addr_reg;
        load_data_next     = load_data_reg;
        option_shadow_next = option_shadow_reg;
        pin_next           = pin_reg;
        reject_next        = 1'b0;
        case (state_reg)
            H_IDLE: begin
                if (STANDBY_REQ) begin
                    // the mode bit goes out first, the pin follows
                    option_shadow_next[clkgen_pkg::OPT_STBY_MODE_BIT] =
                        STANDBY_DEEP;
                    load_valid_next = 1'b1;
                    load_addr_next  = clkgen_pkg::ADDR_OPTION;
                    load_data_next  = option_shadow_next;
                    state_next      = H_PREP;
                end else if (CMD_VALID) begin
                    if (is_freq && !in_range) begin
                        reject_next = 1'b1;
                    end else begin
                        load_valid_next = 1'b1;
                        load_addr_next  = CMD_ADDR;
                        load_data_next  = CMD_DATA;
                        if (CMD_ADDR == clkgen_pkg::ADDR_OPTION) begin
                            option_shadow_next = CMD_DATA;
                        end
                    end
                end
            end
            H_PREP: begin
                pin_next   = 1'b0;
                state_next = H_LOW;
            end
            H_LOW: begin
                if (!STANDBY_REQ) begin
                    pin_next   = 1'b1;
                    state_next = H_IDLE;
                end
            end
            default: begin
                state_next = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg         <= H_IDLE;
            load_valid_reg    <= 1'b0;
            load_addr_reg     <= 3'h0;
            load_data_reg     <= 21'h000000;
            option_shadow_reg <= clkgen_pkg::OPTION_RESET;
            pin_reg           <= 1'b1;
            reject_reg        <= 1'b0;
        end else begin
            state_reg         <= state_next;
            load_valid_reg    <= load_valid_next;
            load_addr_reg     <= load_addr_next;
            load_data_reg     <= load_data_next;
            option_shadow_reg <= option_shadow_next;
            pin_reg           <= pin_next;
            reject_reg        <= reject_next;
        end
    end

    assign link.load_valid        = load_valid_reg;
    assign link.load_addr         = load_addr_reg;
    assign link.load_data         = load_data_reg;
    assign link.sel               = SEL_REQ;
    assign link.standby_request_n = pin_reg;
    assign CMD_REJECT             = reject_reg;
    assign STANDBY_ACTIVE         = !pin_reg;
endmodule : clock_word_programmer

// file: test/clkgen_properties.sv
// timing relations between the word link and the decoder outputs
`timescale 1ns/1ns
module clkgen_properties (
    input logic                 CLK,
    input logic                 RST,
    input logic                 load_valid,
    input logic [2:0]           load_addr,
    input logic [20:0]          load_data,
    input logic                 standby_request_n,
    input clkgen_pkg::decode_t  PIX_CFG,
    input clkgen_pkg::pix_src_t PIXEL_CLOCK_OUT_SEL,
    input logic                 PIX_VCO_ON,
    input clkgen_pkg::decode_t  MEM_CFG,
    input clkgen_pkg::mem_src_t MEM_CLOCK_SEL,
    input logic                 MEM_VCO_ON,
    input logic                 OSC_ON,
    input clkgen_pkg::stby_t    STANDBY_STATE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    logic       mem_wr;
    logic [3:0] idx;
    logic       run;
    assign mem_wr = load_valid && load_addr == clkgen_pkg::ADDR_MEM;
    assign idx    = PIX_CFG.index;
    assign run    = STANDBY_STATE == clkgen_pkg::ST_RUN;

    property p_mem_nm;
        mem_wr |-> ##2
            MEM_CFG.n_eff == {1'b0, $past(load_data[16:10], 2)} + 8'h03
            && MEM_CFG.m_eff == {1'b0, $past(load_data[6:0], 2)} + 8'h02;
    endproperty
    a_mem_nm: assert property (p_mem_nm)
        else $error("memory dividers wrong");
    property p_mem_div;
        mem_wr |-> ##2
            (MEM_CFG.divisor == (8'h01 << $past(load_data[9:7], 2)))
            && MEM_CFG.index == $past(load_data[20:17], 2);
    endproperty
    a_mem_div: assert property (p_mem_div)
        else $error("memory divisor wrong");
    // three samples give the select room to follow the return from standby
    property p_pix_off;
        (idx == clkgen_pkg::IDX_PIX_OFF && run)[*3]
            |-> PIXEL_CLOCK_OUT_SEL == clkgen_pkg::PIX_OFF;
    endproperty
    a_pix_off: assert property (p_pix_off)
        else $error("pixel not off");
    property p_pix_mem;
        (idx == clkgen_pkg::IDX_PIX_FROM_MEM && run)[*3]
            |-> PIXEL_CLOCK_OUT_SEL == clkgen_pkg::PIX_MEM && !PIX_VCO_ON;
    endproperty
    a_pix_mem: assert property (p_pix_mem)
        else $error("pixel not muxed");
    property p_pix_own;
        (idx[3:1] != 3'h7 && run)[*3]
            |-> PIXEL_CLOCK_OUT_SEL == clkgen_pkg::PIX_OWN && PIX_VCO_ON;
    endproperty
    a_pix_own: assert property (p_pix_own)
        else $error("pixel not own");
    property p_slow;
        (STANDBY_STATE == clkgen_pkg::ST_SLOW)[*2]
            |-> PIXEL_CLOCK_OUT_SEL == clkgen_pkg::PIX_HIGH && !PIX_VCO_ON
            && MEM_CLOCK_SEL == clkgen_pkg::MEM_SLOW && !MEM_VCO_ON;
    endproperty
    a_slow: assert property (p_slow)
        else $error("slow standby wrong");
    property p_deep;
        (STANDBY_STATE == clkgen_pkg::ST_DEEP)[*2]
            |-> PIXEL_CLOCK_OUT_SEL == clkgen_pkg::PIX_STOP && !OSC_ON
            && MEM_CLOCK_SEL == clkgen_pkg::MEM_STOP && !MEM_VCO_ON
            && !PIX_VCO_ON;
    endproperty
    a_deep: assert property (p_deep)
        else $error("deep standby wrong");
    property p_order;
        $fell(standby_request_n) |-> $past(load_valid)
            && $past(load_addr) == clkgen_pkg::ADDR_OPTION;
    endproperty
    a_order: assert property (p_order)
        else $error("pin before mode");
    property p_enter;
        $fell(standby_request_n) |-> ##3 STANDBY_STATE == ($past(load_data[20],
            4) ? clkgen_pkg::ST_DEEP : clkgen_pkg::ST_SLOW);
    endproperty
    a_enter: assert property (p_enter)
        else $error("wrong standby mode");
    property p_wake;
        $rose(standby_request_n) |-> ##3 run;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake up");
endmodule : clkgen_properties

// file: test/dual_clock_word_decode_powerdown_bench.sv
// bench joining controller and decoder ends over the word link
`timescale 1ns/1ns
module dual_clock_word_decode_powerdown_bench;
    typedef struct packed {
        logic [2:0]  a;
        logic [1:0]  s;
        logic [20:0] w;
        logic [7:0]  n;
        logic [7:0]  m;
        logic [7:0]  d;
        logic [4:0]  src;
    } row_t;
    // word = index, N code, divisor select, M code; all inside vco range
    localparam row_t ROWS [8] = '{
        '{3'h3, 2'h0, {4'he, 7'h2f, 3'h7, 7'h12}, 8'h32, 8'h14, 8'h80, 5'h01},
        '{3'h0, 2'h0, {4'h5, 7'h07, 3'h0, 7'h02}, 8'h0a, 8'h04, 8'h01, 5'h01},
        '{3'h1, 2'h1, {4'h0, 7'h11, 3'h1, 7'h06}, 8'h14, 8'h08, 8'h02, 5'h01},
        '{3'h2, 2'h2, {4'h3, 7'h7f, 3'h2, 7'h28}, 8'h82, 8'h2a, 8'h04, 5'h01},
        '{3'h2, 2'h3, {4'h9, 7'h04, 3'h3, 7'h01}, 8'h07, 8'h03, 8'h08, 5'h01},
        '{3'h0, 2'h0, {4'hc, 7'h1b, 3'h4, 7'h08}, 8'h1e, 8'h0a, 8'h10, 5'h01},
        '{3'h1, 2'h1, {4'he, 7'h25, 3'h5, 7'h0a}, 8'h28, 8'h0c, 8'h20, 5'h02},
        '{3'h0, 2'h0, {4'hf, 7'h39, 3'h6, 7'h12}, 8'h32, 8'h14, 8'h40, 5'h04}};
    localparam logic [3:0] CODES [4] = '{4'h8, 4'hf, 4'h1, 4'h0};
    localparam int         PERIODS [4] = '{18, 4, 32, 18};
    logic                 clk, rst, cmd_valid, cmd_ready, cmd_reject;
    logic [2:0]           cmd_addr;
    logic [20:0]          cmd_data;
    logic [1:0]           sel_req;
    logic                 stby_req, stby_deep, pix_vco_on, mem_vco_on;
    logic                 slow_clk, osc_on, stby_act;
    clkgen_pkg::decode_t  pix_cfg, mem_cfg, cfg;
    clkgen_pkg::pix_src_t pix_sel;
    clkgen_pkg::mem_src_t mem_sel;
    clkgen_pkg::stby_t    stby_state;
    int                   n_fail = 0, n_checks = 0, n_rej = 0, p;

    clkgen_if clkgen_if_i ();
    clock_word_programmer clock_word_programmer_i (.CLK(clk), .RST(rst),
        .link(clkgen_if_i), .CMD_VALID(cmd_valid), .CMD_ADDR(cmd_addr),
        .CMD_DATA(cmd_data), .CMD_READY(cmd_ready), .CMD_REJECT(cmd_reject),
        .SEL_REQ(sel_req), .STANDBY_REQ(stby_req), .STANDBY_DEEP(stby_deep),
        .STANDBY_ACTIVE(stby_act));
    clock_word_decoder clock_word_decoder_i (.CLK(clk), .RST(rst),
        .link(clkgen_if_i), .PIX_CFG(pix_cfg), .PIXEL_CLOCK_OUT_SEL(pix_sel),
        .PIX_VCO_ON(pix_vco_on), .MEM_CFG(mem_cfg), .MEM_CLOCK_SEL(mem_sel),
        .MEM_VCO_ON(mem_vco_on), .STANDBY_MEMORY_FREQ_CLK(slow_clk),
        .OSC_ON(osc_on), .STANDBY_STATE(stby_state));
    clkgen_properties clkgen_properties_i (.CLK(clk), .RST(rst),
        .load_valid(clkgen_if_i.load_valid),
        .load_addr(clkgen_if_i.load_addr), .load_data(clkgen_if_i.load_data),
        .standby_request_n(clkgen_if_i.standby_request_n), .PIX_CFG(pix_cfg),
        .PIXEL_CLOCK_OUT_SEL(pix_sel), .PIX_VCO_ON(pix_vco_on),
        .MEM_CFG(mem_cfg), .MEM_CLOCK_SEL(mem_sel), .MEM_VCO_ON(mem_vco_on),
        .OSC_ON(osc_on), .STANDBY_STATE(stby_state));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (cmd_reject === 1'b1) begin
            n_rej <= n_rej + 1;
        end
    end

    task final_report;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    task check(input string nm, input logic [31:0] seen,
               input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check
    task put(input logic [2:0] a, input logic [20:0] d);
        int k;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_addr  <= a;
        cmd_data  <= d;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (cmd_ready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_fail++;
            final_report();
        end
        @(posedge clk);
        cmd_valid <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : put
    // pin falls two cycles after the request, outputs settle four later
    task pin_req(input logic deep, input logic req);
        @(posedge clk);
        stby_deep <= deep;
        stby_req  <= req;
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask : pin_req
    task wait_lvl(input logic v, output int c);
        c = 0;
        while (slow_clk !== v && c < 100) begin
            @(negedge clk);
            c++;
        end
        if (slow_clk !== v) begin
            n_fail++;
            final_report();
        end
    endtask : wait_lvl
    task period(output int q);
        int a, b;
        wait_lvl(1'b0, a);
        wait_lvl(1'b1, a);
        wait_lvl(1'b0, a);
        wait_lvl(1'b1, b);
        q = a + b;
    endtask : period

    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_addr = 3'h0;
        cmd_data = 21'h000000;
        sel_req = 2'h0;
        stby_req = 1'b0;
        stby_deep = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(negedge clk);
        check("state", stby_state, clkgen_pkg::ST_RUN);
        check("mem_n", mem_cfg.n_eff, 8'h03);
        check("mem_m", mem_cfg.m_eff, 8'h02);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            sel_req <= ROWS[i].s;
            put(ROWS[i].a, ROWS[i].w);
            cfg = (ROWS[i].a == clkgen_pkg::ADDR_MEM) ? mem_cfg : pix_cfg;
            check("n", cfg.n_eff, ROWS[i].n);
            check("m", cfg.m_eff, ROWS[i].m);
            check("div", cfg.divisor, ROWS[i].d);
            check("idx", cfg.index, ROWS[i].w[20:17]);
            check("src", (ROWS[i].a == clkgen_pkg::ADDR_MEM) ? 5'(mem_sel)
                : 5'(pix_sel), ROWS[i].src);
        end
        put(3'h0, {4'h0, 7'h00, 3'h0, 7'h7f});
        check("reject", n_rej, 1);
        check("kept", pix_cfg.divisor, 8'h40);
        // code 0 is invalid; the decoder falls back to the default
        for (int i = 0; i < 4; i++) begin
            put(clkgen_pkg::ADDR_STBY_DIV, {17'h0, CODES[i]});
            pin_req(1'b0, 1'b1);
            check("slow", stby_state, clkgen_pkg::ST_SLOW);
            check("pix_high", pix_sel, clkgen_pkg::PIX_HIGH);
            period(p);
            check("period", p, PERIODS[i]);
            pin_req(1'b0, 1'b0);
            check("run", stby_state, clkgen_pkg::ST_RUN);
        end
        pin_req(1'b1, 1'b1);
        check("deep", stby_state, clkgen_pkg::ST_DEEP);
        check("osc", osc_on, 1'b0);
        check("mem_stop", mem_sel, clkgen_pkg::MEM_STOP);
        check("active", stby_act, 1'b1);
        pin_req(1'b0, 1'b0);
        check("kept_pix", pix_cfg.divisor, 8'h40);
        check("kept_mem", mem_cfg.n_eff, 8'h32);
        check("osc_back", osc_on, 1'b1);
        check("idle", stby_act, 1'b0);
        put(clkgen_pkg::ADDR_OPTION, 21'h011000);
        put(3'h0, {4'h0, 7'h7f, 3'h0, 7'h7f});
        check("prescale", pix_cfg.prescale, 3'h4);
        check("m_max", pix_cfg.m_eff, 8'h81);
        final_report();
    end
endmodule : dual_clock_word_decode_powerdown_bench
